// >>> design/eq_fir_top.sv
// Programmable nine-tap equalizer with AXI4-Lite register access
//
// The AXI4-Lite register port and the register addresses were decided locally.
module eq_fir_top (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [eq_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic [2:0]                 awprot,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic      [1:0]                 bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [eq_pkg::ADDR_W-1:0]  araddr,
	input  wire logic [2:0]                 arprot,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic      [31:0]                rdata,
	output logic      [1:0]                 rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire eq_pkg::eq_smp_s            smp_in,
	output eq_pkg::eq_smp_s                 smp_out
);

	// Write channel holding registers
	logic                       aw_full;
	logic                       w_full;
	logic [eq_pkg::ADDR_W-1:0]  aw_addr;
	logic [31:0]                w_data;
	logic [3:0]                 w_strb;
	logic [31:0]                ctrl;
	logic [31:0]                next_ctrl;
	logic [31:0]                rd_reg;
	logic                       rd_mem_sel;
	logic                       tv_phase;
	eq_pkg::eq_opt_e            opt;

	// Coefficient store wiring
	logic [eq_pkg::CTAP_W-1:0]                    mem_rd;
	logic [eq_pkg::NWORDS-1:0][eq_pkg::CTAP_W-1:0] coef;
	logic [eq_pkg::IDX_W-1:0]                     wr_idx;
	logic [eq_pkg::IDX_W-1:0]                     rd_idx;
	logic [eq_pkg::CTAP_W-1:0]                    wr_coef;

	// Protection bits carry no meaning here
	wire unused_prot = ^{awprot, arprot};

	assign awready = !aw_full;
	assign wready  = !w_full;
	assign arready = !rvalid;

	wire aw_take = awvalid && awready;
	wire w_take  = wvalid && wready;
	wire ar_take = arvalid && arready;
	wire wr_fire = aw_full && w_full && !bvalid;

	// Write address decode
	wire       wr_ctrl = aw_addr[11:2] == eq_pkg::CTRL_OFF[11:2];
	wire       wr_stat = aw_addr[11:2] == eq_pkg::STAT_OFF[11:2];
	wire [3:0] wr_tap  = aw_addr[5:2];
	wire       wr_tapok = int'(wr_tap) < eq_pkg::NTAPS;
	wire       wr_set1 = aw_addr[11:6] == eq_pkg::SET1_BASE[11:6] && wr_tapok;
	wire       wr_set2 = aw_addr[11:6] == eq_pkg::SET2_BASE[11:6] && wr_tapok;
	wire       wr_hit  = wr_ctrl || wr_stat || wr_set1 || wr_set2;
	wire       wr_center = int'(wr_tap) == eq_pkg::CENTER;

	// Partial writes to a coefficient would tear it, so all three low lanes are needed
	wire wr_coef_en = wr_fire && (wr_set1 || wr_set2) && (w_strb[2:0] == 3'h7);

	assign wr_idx = {1'b0, wr_tap} + (wr_set2 ? eq_pkg::SET2_IDX_BASE : 5'h00);

	// Non-center taps keep 12 bits, sign extended in the store
	assign wr_coef = wr_center ? w_data[eq_pkg::CTAP_W-1:0] :
		{{(eq_pkg::CTAP_W - eq_pkg::NTAP_W){w_data[eq_pkg::NTAP_W-1]}},
		w_data[eq_pkg::NTAP_W-1:0]};

	// Read address decode
	wire       rd_ctrl  = araddr[11:2] == eq_pkg::CTRL_OFF[11:2];
	wire       rd_stat  = araddr[11:2] == eq_pkg::STAT_OFF[11:2];
	wire [3:0] rd_tap   = araddr[5:2];
	wire       rd_tapok = int'(rd_tap) < eq_pkg::NTAPS;
	wire       rd_set1  = araddr[11:6] == eq_pkg::SET1_BASE[11:6] && rd_tapok;
	wire       rd_set2  = araddr[11:6] == eq_pkg::SET2_BASE[11:6] && rd_tapok;
	wire       rd_coef  = rd_set1 || rd_set2;
	wire       rd_hit   = rd_ctrl || rd_stat || rd_coef;

	assign rd_idx = {1'b0, rd_tap} + (rd_set2 ? eq_pkg::SET2_IDX_BASE : 5'h00);

	// Control fields
	wire [1:0] mode        = ctrl[eq_pkg::MODE_LSB +: 2];
	wire       share       = ctrl[eq_pkg::SHARE_BIT];
	wire       merge       = ctrl[eq_pkg::MERGE_BIT];
	wire [2:0] wsel        = ctrl[eq_pkg::WSEL_LSB +: 3];
	wire       link_single = ctrl[eq_pkg::LINK_BIT];
	wire       single_in   = ctrl[eq_pkg::SINGLE_BIT];

	// Option selection; modes other than 2 leave the filter off
	wire mode_eq   = mode == eq_pkg::MODE_EQ;
	wire cfg_dual  = mode_eq && !share && !merge && !link_single;
	wire cfg_single = mode_eq && share && merge && link_single;
	wire cfg_tv    = mode_eq && !share && merge && link_single && !single_in;
	wire cfg_block = mode_eq && !cfg_dual && !cfg_single && !cfg_tv;

	assign opt = cfg_dual ? eq_pkg::EQ_DUAL :
		cfg_single ? eq_pkg::EQ_SINGLE :
		cfg_tv ? eq_pkg::EQ_TV : eq_pkg::EQ_OFF;

	// Shared non-center weight; codes above 6 behave as 2^-16
	wire [2:0] wsel_lim = (wsel > eq_pkg::WSEL_MAX) ? eq_pkg::WSEL_MAX : wsel;
	wire [2:0] nshift   = eq_pkg::WSEL_MAX - wsel_lim;

	wire [31:0] stat_word = {28'h0, cfg_block, tv_phase, opt};

	// Byte-lane merge for the control word
	always_comb begin
		next_ctrl = ctrl;
		for (int i = 0; i < 4; i++) begin
			if (w_strb[i])
				next_ctrl[8*i +: 8] = w_data[8*i +: 8];
		end
		next_ctrl = next_ctrl & eq_pkg::CTRL_MASK;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			aw_full <= 1'b0;
		else if (aw_take)
			aw_full <= 1'b1;
		else if (wr_fire)
			aw_full <= 1'b0;
	end

	// Address holds while the data beat is still missing
	always_ff @(posedge aclk) begin
		if (!aresetn)
			aw_addr <= '0;
		else if (aw_take)
			aw_addr <= awaddr;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			w_full <= 1'b0;
		else if (w_take)
			w_full <= 1'b1;
		else if (wr_fire)
			w_full <= 1'b0;
	end

	// Data holds while the address beat is still missing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_data <= '0;
			w_strb <= '0;
		end else if (w_take) begin
			w_data <= wdata;
			w_strb <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl <= eq_pkg::CTRL_RST;
		else if (wr_fire && wr_ctrl)
			ctrl <= next_ctrl;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			bvalid <= 1'b0;
		else if (wr_fire)
			bvalid <= 1'b1;
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			bresp <= eq_pkg::RESP_OKAY;
		else if (wr_fire)
			bresp <= wr_hit ? eq_pkg::RESP_OKAY : eq_pkg::RESP_SLVERR;
	end

	// Read side: one beat, data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rvalid <= 1'b0;
		else if (ar_take)
			rvalid <= 1'b1;
		else if (rready)
			rvalid <= 1'b0;
	end

	// Payload stays put until the next accepted address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rresp      <= eq_pkg::RESP_OKAY;
			rd_reg     <= '0;
			rd_mem_sel <= 1'b0;
		end else if (ar_take) begin
			rresp      <= rd_hit ? eq_pkg::RESP_OKAY : eq_pkg::RESP_SLVERR;
			rd_reg     <= rd_ctrl ? ctrl : (rd_stat ? stat_word : 32'h0);
			rd_mem_sel <= rd_coef;
		end
	end

	assign rdata = rd_mem_sel ? {{(32 - eq_pkg::CTAP_W){1'b0}}, mem_rd} : rd_reg;

	eq_coef_mem i_eq_coef_mem (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_coef_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_coef),
		.rd_en   (ar_take && rd_coef),
		.rd_idx  (rd_idx),
		.rd_data (mem_rd),
		.coef    (coef)
	);

	// Set alternates per accepted sample only in the time-varying option
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tv_phase <= 1'b0;
		else if (opt != eq_pkg::EQ_TV)
			tv_phase <= 1'b0;
		else if (smp_in.valid)
			tv_phase <= !tv_phase;
	end

	// Output samples and valid, one cycle after the input
	logic [eq_pkg::SMP_W-1:0] y_q [0:1];
	logic                     out_valid;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			out_valid <= 1'b0;
		else
			out_valid <= smp_in.valid;
	end

	// Per-channel delay line and multiply-accumulate
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic signed [eq_pkg::SMP_W-1:0] line [0:eq_pkg::NTAPS-2];
		logic signed [eq_pkg::SMP_W-1:0] win  [0:eq_pkg::NTAPS-1];
		logic signed [eq_pkg::SMP_W-1:0] x_in;
		logic signed [eq_pkg::ACC_W-1:0] acc;
		logic        [eq_pkg::SMP_W-1:0] y_sat;
		logic                            sel2;
		logic                            active;

		assign x_in = (ch == 0) ? smp_in.a : smp_in.b;

		// Channel B takes the second set only in dual use; channel A only on odd TV samples
		assign sel2 = (ch == 1) ? (opt == eq_pkg::EQ_DUAL) :
			(opt == eq_pkg::EQ_TV && tv_phase);

		// Single-stream options filter channel A; B passes through
		assign active = (ch == 0) ? (opt != eq_pkg::EQ_OFF) :
			(opt == eq_pkg::EQ_DUAL);

		// Newest sample at tap 0, center tap at the middle delay
		assign win[0] = x_in;
		for (genvar k = 1; k < eq_pkg::NTAPS; k++) begin : g_win
			assign win[k] = line[k-1];
		end

		always_comb begin
			logic signed [eq_pkg::CTAP_W-1:0]  cc;
			logic signed [eq_pkg::NTAP_W-1:0]  cn;
			logic signed [eq_pkg::PROD_W-1:0]  p;
			logic signed [eq_pkg::NPROD_W-1:0] pn;
			cc  = '0;
			cn  = '0;
			p   = '0;
			pn  = '0;
			acc = '0;
			for (int k = 0; k < eq_pkg::NTAPS; k++) begin
				cc = $signed(coef[sel2 ? k + eq_pkg::NTAPS : k]);
				cn = cc[eq_pkg::NTAP_W-1:0];
				if (k == eq_pkg::CENTER) begin
					p = win[k] * cc;
				end else begin
					pn = win[k] * cn;
					p  = eq_pkg::PROD_W'(pn) <<< nshift;
				end
				acc = acc + eq_pkg::ACC_W'(p);
			end
		end

		// Drop the 2^-16 fraction and saturate to sample width
		wire [eq_pkg::ACC_W-eq_pkg::FRAC-eq_pkg::SMP_W:0] hi =
			acc[eq_pkg::ACC_W-1:eq_pkg::FRAC+eq_pkg::SMP_W-1];
		wire fits = (&hi) || !(|hi);

		assign y_sat = fits ? acc[eq_pkg::FRAC +: eq_pkg::SMP_W] :
			(acc[eq_pkg::ACC_W-1] ? eq_pkg::SAT_MIN : eq_pkg::SAT_MAX);

		// History shifts in every option so a change of option keeps it
		for (genvar k = 0; k < eq_pkg::NTAPS - 1; k++) begin : g_line
			always_ff @(posedge aclk) begin
				if (!aresetn)
					line[k] <= '0;
				else if (smp_in.valid)
					line[k] <= win[k];
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn)
				y_q[ch] <= '0;
			else if (smp_in.valid)
				y_q[ch] <= active ? y_sat : x_in;
		end
	end

	assign smp_out.valid = out_valid;
	assign smp_out.a     = y_q[0];
	assign smp_out.b     = y_q[1];

endmodule

// >>> design/eq_pkg.sv
// Constants and types shared by the programmable equalizer files
// Functional notes
// - Converter samples may be routed through the equalizer before going on to the output path.
// - Dual-channel equalization is allowed only while the link mode selects dual-channel use.
// - In dual-channel equalization each channel has its own nine programmable coefficients.
// - The center tap is an 18-bit coefficient whose LSB weighs two to the minus sixteenth.
// - Non-center taps are 12-bit coefficients with an LSB weight from 2^-10 down to 2^-16.
// - One selected LSB weight applies to all non-center taps together.
// - Single-channel equalization is allowed only while the link mode selects single-channel use.
// - Single-channel equalization uses one set of nine programmable coefficients.
// - The time-varying option needs dual-input single-channel use and swaps sets every sample.
// - Each of the two time-varying coefficient sets holds nine programmable coefficients.
// - Mode 0 disables filtering; mode 2 with share/merge 00, 11 and 01 picks dual, single, time-varying.
package eq_pkg;

	localparam int SMP_W   = 16;
	localparam int CTAP_W  = 18;
	localparam int NTAP_W  = 12;
	localparam int NTAPS   = 9;
	localparam int CENTER  = 4;
	localparam int NWORDS  = 18;
	localparam int IDX_W   = 5;
	localparam int FRAC    = 16;
	localparam int PROD_W  = 34;
	localparam int NPROD_W = 28;
	localparam int ACC_W   = 40;
	localparam int ADDR_W  = 12;

	localparam logic [IDX_W-1:0]  SET2_IDX_BASE = 5'h09;
	localparam logic [CTAP_W-1:0] CENTER_RST    = 18'h10000;
	localparam logic [SMP_W-1:0]  SAT_MAX       = 16'h7fff;
	localparam logic [SMP_W-1:0]  SAT_MIN       = 16'h8000;

	localparam logic [ADDR_W-1:0] CTRL_OFF  = 12'h000;
	localparam logic [ADDR_W-1:0] STAT_OFF  = 12'h004;
	localparam logic [ADDR_W-1:0] SET1_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] SET2_BASE = 12'h080;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0003_0733;
	localparam int MODE_LSB   = 0;
	localparam int SHARE_BIT  = 4;
	localparam int MERGE_BIT  = 5;
	localparam int WSEL_LSB   = 8;
	localparam int LINK_BIT   = 16;
	localparam int SINGLE_BIT = 17;

	localparam logic [1:0] MODE_EQ  = 2'h2;
	localparam logic [2:0] WSEL_MAX = 3'h6;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {EQ_OFF, EQ_DUAL, EQ_SINGLE, EQ_TV} eq_opt_e;

	typedef struct packed {
		logic              valid;
		logic [SMP_W-1:0]  a;
		logic [SMP_W-1:0]  b;
	} eq_smp_s;

endpackage

// >>> design/eq_coef_mem.sv
// Coefficient store: two sets of nine taps, registered read port
module eq_coef_mem (
	input  wire logic                                     aclk,
	input  wire logic                                     aresetn,
	input  wire logic                                     wr_en,
	input  wire logic [eq_pkg::IDX_W-1:0]                 wr_idx,
	input  wire logic [eq_pkg::CTAP_W-1:0]                wr_data,
	input  wire logic                                     rd_en,
	input  wire logic [eq_pkg::IDX_W-1:0]                 rd_idx,
	output logic      [eq_pkg::CTAP_W-1:0]                rd_data,
	output logic      [eq_pkg::NWORDS-1:0][eq_pkg::CTAP_W-1:0] coef
);

	// Center taps start at unity so an enabled filter passes data
	for (genvar i = 0; i < eq_pkg::NWORDS; i++) begin : g_word
		always_ff @(posedge aclk) begin
			if (!aresetn)
				coef[i] <= ((i % eq_pkg::NTAPS) == eq_pkg::CENTER) ? eq_pkg::CENTER_RST : '0;
			else if (wr_en && int'(wr_idx) == i)
				coef[i] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= (int'(rd_idx) < eq_pkg::NWORDS) ? coef[rd_idx] : '0;
	end

endmodule

// >>> verification/eq_fir_checker.sv
// Port assertions for the equalizer top
module eq_fir_checker (
	input	wire logic		aclk,
	input	wire logic		aresetn,
	input	wire logic		awvalid,
	input	wire logic		awready,
	input	wire logic		wvalid,
	input	wire logic		wready,
	input	wire logic [1:0]	bresp,
	input	wire logic		bvalid,
	input	wire logic		bready,
	input	wire logic		arvalid,
	input	wire logic		arready,
	input	wire logic		rvalid,
	input	wire logic		rready,
	input	wire eq_pkg::eq_smp_s	smp_in,
	input	wire eq_pkg::eq_smp_s	smp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_vld; smp_in.valid |=> smp_out.valid; endproperty
	property p_one; !smp_in.valid |=> !smp_out.valid; endproperty
	property p_hold; !smp_out.valid |-> $stable(smp_out.a) && $stable(smp_out.b); endproperty
	property p_aw; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
	property p_awl; awvalid && awready |=> !awready; endproperty
	property p_br; bvalid && bready |=> !bvalid; endproperty
	property p_ar; arvalid && arready |=> rvalid && !arready; endproperty
	property p_rr; rvalid && rready |=> !rvalid && arready; endproperty
	a_vld: assert property (p_vld) else $error("sample output missing");
	a_one: assert property (p_one) else $error("extra sample output");
	a_hold: assert property (p_hold) else $error("output moved while idle");
	a_aw: assert property (p_aw) else $error("write response late");
	a_awl: assert property (p_awl) else $error("address accepted twice");
	a_br: assert property (p_br) else $error("write response stuck");
	a_ar: assert property (p_ar) else $error("read data late");
	a_rr: assert property (p_rr) else $error("read data stuck");
	c_b2b: cover property (smp_in.valid ##1 smp_in.valid);
	c_err: cover property (bvalid && bresp == eq_pkg::RESP_SLVERR);
	c_rd: cover property (rvalid && rready);
endmodule

bind eq_fir_top eq_fir_checker i_eq_fir_checker (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .smp_in(smp_in), .smp_out(smp_out));

// >>> verification/eq_conv_src.sv
// Converter-side sample source feeding the equalizer
module eq_conv_src (
	input	wire logic		aclk,
	input	wire logic		aresetn,
	input	wire logic		req,
	input	wire logic [15:0]	req_a,
	input	wire logic [15:0]	req_b,
	output	eq_pkg::eq_smp_s	smp
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle data inverts so stale values never look held
	always_ff @(posedge aclk) begin
		if (!aresetn)
			smp <= '0;
		else if (req)
			smp <= {1'b1, req_a, req_b};
		else
			smp <= {1'b0, ~smp.a, ~smp.b};
	end
endmodule

// >>> verification/tb_eq_fir_top.sv
// Self-checking bench for the programmable equalizer
module tb_eq_fir_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] ALL = 64'h3_ffff_ffff;
	logic			aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req;
	logic			awready, wready, bvalid, arready, rvalid;
	logic [1:0]		bresp, rresp;
	logic [11:0]		awaddr, araddr, a;
	logic [31:0]		wdata, rdata, rnd, c, d;
	logic [15:0]		ra, rb;
	logic [3:0]		wstrb, ws;
	eq_pkg::eq_smp_s	smp_in, smp_out;
	int			miscompares, n_compared, wq, opt, ph, no;
	int			cf[2][9], h[2][9];
	logic [63:0]		sq[$], rq[$], mq[$], bq[$];
	logic [31:0]		cfg[8] = '{32'h2, 32'h32, 32'h1_0032, 32'h1_0012,
					32'h1_0022, 32'h3_0022, 32'h1_0031, 32'h0};
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	eq_conv_src i_eq_conv_src (.aclk(aclk), .aresetn(aresetn), .req(req), .req_a(ra),
		.req_b(rb), .smp(smp_in));
	eq_fir_top i_eq_fir_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.smp_in(smp_in), .smp_out(smp_out));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [63:0] s, e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic int fir(int ch, int s);
		longint acc;
		acc = 0;
		for (int k = 0; k < 9; k++)
			acc += k == 4 ? longint'(h[ch][k]) * cf[s][k]
				: (longint'(h[ch][k]) * cf[s][k]) <<< (6 - wq);
		acc = acc >>> 16;
		return acc > 32767 ? 32767 : acc < -32768 ? -32768 : int'(acc);
	endfunction
	task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [63:0] r);
		bit pa, pd;
		bq.push_back(r);
		awaddr <= ad;
		wdata <= dt;
		wstrb <= ws;
		pa = 0;
		pd = 0;
		do begin
			awvalid <= !pa;
			wvalid <= !pd;
			@(posedge aclk);
			pa |= awready;
			pd |= wready;
		end while (!(pa && pd));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [63:0] e, m);
		rq.push_back(e);
		mq.push_back(m);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask
	task automatic send(input logic [15:0] sa, sb);
		int ya, yb;
		for (int k = 8; k > 0; k--) begin
			h[0][k] = h[0][k-1];
			h[1][k] = h[1][k-1];
		end
		h[0][0] = $signed(sa);
		h[1][0] = $signed(sb);
		ya = h[0][0];
		yb = h[1][0];
		if (opt != 0) ya = fir(0, opt == 3 ? ph : 0);
		if (opt == 1) yb = fir(1, 1);
		if (opt == 3) ph ^= 1;
		sq.push_back({ya[15:0], yb[15:0]});
		req <= 1'b1;
		ra <= sa;
		rb <= sb;
		@(posedge aclk);
	endtask
	task automatic drain;
		req <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (smp_out.valid)
			chk({smp_out.a, smp_out.b}, sq.size() > 0 ? sq.pop_front() : 'x);
		if (bvalid && bready)
			chk(bresp, bq.pop_front());
		if (rvalid && rready)
			chk({rresp, rdata} & mq.pop_front(), rq.pop_front());
	end
	initial begin
		{aresetn, awvalid, wvalid, arvalid, req, bready, rready} = '0;
		{awaddr, araddr, wdata, ra, rb} = '0;
		wstrb = 4'h0;
		ws = 4'hf;
		rnd = 32'h8425aee1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		bready <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		rd(eq_pkg::CTRL_OFF, 0, ALL);
		rd(12'h050, 64'h1_0000, ALL);
		rd(12'h090, 64'h1_0000, ALL);
		// Partial coefficient write must leave the tap untouched
		ws = 4'h3;
		wr(12'h050, 32'h0000_1234, 0);
		ws = 4'hf;
		rd(12'h050, 64'h1_0000, ALL);
		wr(12'h064, 32'hffff_ffff, 2);
		rd(12'h0a4, 64'h2_0000_0000, ALL);
		wr(eq_pkg::STAT_OFF, 32'hffff_ffff, 0);
		for (int i = 0; i < 8; i++) begin
			// Bit 17 cleared: center sign handling is left open
			for (int t = 0; t < 18; t++) begin
				rnd = xs(rnd);
				d = rnd & 32'hfffd_ffff;
				a = 12'h040 + 12'(t / 9 * 64 + t % 9 * 4);
				wr(a, d, 0);
				cf[t/9][t%9] = t % 9 == 4 ? int'(d[17:0]) : int'($signed(d[11:0]));
				if (t % 9 == i)
					rd(a, t % 9 == 4 ? 64'(d[17:0]) : 64'({{6{d[11]}}, d[11:0]}), ALL);
			end
			rnd = xs(rnd);
			c = cfg[i] | (rnd & ~eq_pkg::CTRL_MASK) | (rnd & 32'h700);
			wr(eq_pkg::CTRL_OFF, c, 0);
			rd(eq_pkg::CTRL_OFF, 64'(c & eq_pkg::CTRL_MASK), ALL);
			wq = c[10:8] > 6 ? 6 : c[10:8];
			no = c[1:0] != 2 ? 0 : c[5:4] == 0 && !c[16] ? 1 : c[5:4] == 3 && c[16] ? 2
				: c[5:4] == 2 && c[16] && !c[17] ? 3 : 0;
			ph = no == 3 && opt == 3 ? ph : 0;
			opt = no;
			rd(eq_pkg::STAT_OFF, 64'({c[1:0] == 2 && no == 0, 1'b0, no[1:0]}),
				64'h3_0000_000b);
			for (int n = 0; n < 16; n++) begin
				rnd = xs(rnd);
				send(rnd[15:0], rnd[31:16]);
				if (rnd[4]) begin
					req <= 1'b0;
					@(posedge aclk);
				end
			end
			drain();
		end
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		complete_run();
	end
endmodule
